// ==== logic/igoc_period_timer.sv ====
/*
 * Free-run integration period timer: a microsecond tick divider and a
 * microsecond counter compared against the period for the chosen column.
 * Assumes start is a one-cycle pulse from the controller on the same clock.
 */
`timescale 1ns/10ps
module igoc_period_timer import igoc_pkg::*; #(
	parameter int TICK_CYC = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Control
	input  wire logic       start,
	input  wire logic       run,
	input  wire logic [2:0] col,
	input  wire logic [3:0] log2n,
	// Status
	output logic            done
);
	logic [15:0] div_ff;
	logic [15:0] nxt_div;
	logic [21:0] us_ff;
	logic [21:0] nxt_us;
	logic        done_ff;
	logic        nxt_done;
	logic [10:0] n_m1;
	logic [31:0] slope;
	logic [31:0] target;

	// Period grows linearly between the one-sample and 2048-sample figures
	always_comb begin
		n_m1   = 11'((32'h0000_0001 << log2n) - 32'h0000_0001);
		slope  = ((T2048_US[col] - T1_US[col]) << SLOPE_SHIFT) / 32'(MAX_SAMPLES - 1);
		target = T1_US[col] + ((slope * 32'(n_m1)) >> SLOPE_SHIFT); // R1
		nxt_div  = div_ff;
		nxt_us   = us_ff;
		nxt_done = 1'b0;
		if (start) begin
			nxt_div = '0;
			nxt_us  = '0;
		end else if (run) begin
			if (div_ff == 16'(TICK_CYC - 1)) begin
				nxt_div = '0;
				if (32'(us_ff) + 32'h0000_0001 >= target) begin
					nxt_us   = '0;
					nxt_done = 1'b1;
				end else begin
					nxt_us = us_ff + 22'h00_0001;
				end
			end else begin
				nxt_div = div_ff + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_ff  <= '0;
			us_ff   <= '0;
			done_ff <= 1'b0;
		end else begin
			div_ff  <= nxt_div;
			us_ff   <= nxt_us;
			done_ff <= nxt_done;
		end
	end

	assign done = done_ff;

endmodule

// ==== logic/igoc_pkg.sv ====
/*
 * Shared constants for the integration, gain and overflow control block:
 * register offsets, field positions, reset values, timing figures and the
 * free-run integration period table.
 * Assumes a single 125 MHz clock and a byte-wide register port fed by the
 * serial client engine.
 */
// Behaviour
// R1: Free-run period timed from samples, measurement type, resolution and filter setting.
// R2: Current gain code 0..7 multiplies results by 1X up to 128X, default 1X.
// R3: Effective sense full scale halves per current gain step, 100 mV down to 0.78 mV.
// R4: Bus gain codes 0..4 give 1X..16X; codes 5, 6 and 7 all give 32X.
// R5: Effective bus full scale halves per step, 32 V down to 1 V.
// R6: Sense or power overflow sets overflow bit 2; power overflow also sets bit 0. Code sets bit 2 on sense overflow only.
// R7: Sense overflow forces sense results 12h/13h to FFh/C0h.
// R8: Overflow touching power forces power results 1Dh/1Eh to FFh/C0h.
// R9: Accumulators stay exact during overflow; only result registers saturate.
// R10: Bus or power overflow sets overflow bit 1; power overflow also sets bit 0. Code sets bit 1 on bus overflow only.
// R11: Bus overflow forces bus results 10h/11h to FFh/C0h.
// R12: In Read, a recompute request recalculates the last measurement with new gains.
// R13: Resolution, samples and filter writes during Integrate wait until Integrate is re-entered.
// R14: Host should enter Read before changing resolution, sample count or filters.
// R15: Leaving pin-controlled power during Integrate ends measurement at once, updates output.
// R16: Leaving a free-run mode during Integrate finishes the period, updates output, switches.
// R17: Mode select 00 pin power, 01 free sense, 10 free bus, 11 free power.
// R18: Entering Read mid free-run period discards that partial period.
// R19: Sample count caps at 2048; reaching it ends integration and updates results.
// R20: Gains are applied when results are computed from accumulators.
package igoc_pkg;

	// ****************************************
	// Clock and time
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int US_NS         = 1000;
	localparam int TICK_CYCLES   = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// Widths and limits
	// ****************************************
	localparam int SMP_W       = 14;
	localparam int RES_BITS    = 10;
	localparam int CNT_W       = 12;
	localparam int MAX_SAMPLES = 2048;
	localparam int MAX_LOG2N   = 11;
	localparam int SENSE_FS_UV = 100000;
	localparam int BUS_FS_MV   = 32000;
	localparam logic [2:0] BUS_GAIN_MAX = 3'h5;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_GAIN_CFG = 8'h00;
	localparam logic [7:0] OFS_INT_CFG  = 8'h01;
	localparam logic [7:0] OFS_CTRL     = 8'h02;
	localparam logic [7:0] OFS_BUS_HI   = 8'h10;
	localparam logic [7:0] OFS_BUS_LO   = 8'h11;
	localparam logic [7:0] OFS_SENSE_HI = 8'h12;
	localparam logic [7:0] OFS_SENSE_LO = 8'h13;
	localparam logic [7:0] OFS_OVF      = 8'h1C;
	localparam logic [7:0] OFS_PWR_HI   = 8'h1D;
	localparam logic [7:0] OFS_PWR_LO   = 8'h1E;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int GAIN_I_LSB   = 0;
	localparam int GAIN_V_LSB   = 3;
	localparam int INT_IRES_BIT = 0;
	localparam int INT_VRES_BIT = 1;
	localparam int INT_SAMPLE_COUNT_SELECT_LSB = 2;
	localparam int INT_IFLT_BIT = 6;
	localparam int INT_VFLT_BIT = 7;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_RECOMP_BIT = 2;
	localparam int OVF_PWR_BIT  = 0;
	localparam int OVF_BUS_BIT  = 1;
	localparam int OVF_SNS_BIT  = 2;
	localparam logic [7:0]  GAIN_CFG_RST = 8'h00;
	localparam logic [7:0]  INT_CFG_RST  = 8'hC0;
	localparam logic [1:0]  MODE_RST     = 2'h0;
	localparam logic [15:0] RESULT_SAT   = 16'hFFC0;

	typedef enum logic [1:0] {
		MODE_PIN_POWER  = 2'h0,
		MODE_FREE_SENSE = 2'h1,
		MODE_FREE_BUS   = 2'h2,
		MODE_FREE_POWER = 2'h3
	} igoc_mode_t;

	// ****************************************
	// Free-run period table, in microseconds
	// ****************************************
	// Columns: power 14-bit filtered, power 11-bit plain, power mixed,
	// single 14-bit filtered, single 11-bit plain
	localparam logic [2:0] COL_P14F = 3'h0;
	localparam logic [2:0] COL_P11  = 3'h1;
	localparam logic [2:0] COL_PMIX = 3'h2;
	localparam logic [2:0] COL_S14F = 3'h3;
	localparam logic [2:0] COL_S11  = 3'h4;
	localparam int SLOPE_SHIFT = 8;
	localparam logic [31:0] T1_US [0:4]    = '{2720, 930, 2100, 1410, 510};
	localparam logic [31:0] T2048_US [0:4] = '{2941000, 1026000, 2223000, 1460000, 502000};

endpackage

// ==== logic/igoc_result_scaler.sv ====
/*
 * Turns one held accumulator into a left-justified 10-bit result with the
 * digital gain applied, saturating on overflow.
 * Purely combinational; the caller registers the outputs.
 */
`timescale 1ns/10ps
module igoc_result_scaler import igoc_pkg::*; #(
	parameter int DW = SMP_W,
	parameter int AW = SMP_W + MAX_LOG2N
) (
	// Operands
	input  wire logic [AW-1:0] acc,
	input  wire logic [3:0]    log2n,
	input  wire logic [3:0]    gshift,
	// Result
	output logic      [15:0]   result,
	output logic               ovf
);
	logic [AW-1:0]    avg;
	logic [AW+14:0]   gained;

	// Shift only: averaging over a power-of-two count keeps this one cycle
	always_comb begin
		avg    = acc >> log2n;
		gained = {15'h0000, avg} << gshift; // R2 R3 R5 R20
		ovf    = |gained[AW+14:DW];
		result = ovf ? RESULT_SAT : {gained[DW-1 -: RES_BITS], {(16-RES_BITS){1'b0}}};
	end

endmodule

// ==== logic/igoc_top.sv ====
/*
 * Integration, gain and overflow control: accumulates samples, times
 * free-run periods, computes gained results with saturation, keeps the
 * overflow flags and feeds the output DAC.
 * Assumes the serial client engine drives the register port, and the
 * power-state logic and ADC front end share this clock.
 */
`timescale 1ns/10ps
module igoc_top import igoc_pkg::*; #(
	parameter int TICK_CYC = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// Register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic             reg_wr,
	input  wire logic [7:0]       reg_wdata,
	output logic      [7:0]       reg_rdata,
	// Power state, high while in Integrate
	input  wire logic             integrate_req,
	// ADC samples
	input  wire logic             smp_valid,
	input  wire logic [SMP_W-1:0] sense_smp,
	input  wire logic [SMP_W-1:0] bus_smp,
	// Output DAC
	output logic      [9:0]       dac_value,
	output logic                  dac_load,
	output logic                  integrating
);
	localparam int IAW = SMP_W + MAX_LOG2N;
	localparam int PAW = 2 * SMP_W + MAX_LOG2N;

	typedef enum logic {ST_READ, ST_INTEG} igoc_state_t;

	// ****************************************
	// State
	// ****************************************
	igoc_state_t      st_ff, nxt_st;
	logic [7:0]       gain_cfg_ff, nxt_gain_cfg;
	logic [7:0]       int_cfg_ff, nxt_int_cfg;
	logic [7:0]       int_act_ff, nxt_int_act;
	igoc_mode_t       mode_ff, nxt_mode;
	igoc_mode_t       mode_act_ff, nxt_mode_act;
	igoc_mode_t       held_mode_ff, nxt_held_mode;
	logic             recomp_ff, nxt_recomp;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [IAW-1:0]   acc_i_ff, nxt_acc_i, held_i_ff, nxt_held_i;
	logic [IAW-1:0]   acc_v_ff, nxt_acc_v, held_v_ff, nxt_held_v;
	logic [PAW-1:0]   acc_p_ff, nxt_acc_p, held_p_ff, nxt_held_p;
	logic [3:0]       held_log2n_ff, nxt_held_log2n;
	logic             calc_ff, nxt_calc;
	logic [15:0]      bus_res_ff, nxt_bus_res;
	logic [15:0]      sns_res_ff, nxt_sns_res;
	logic [15:0]      pwr_res_ff, nxt_pwr_res;
	logic [2:0]       ovf_ff, nxt_ovf;
	logic [9:0]       dac_ff, nxt_dac;
	logic             dac_load_ff, nxt_dac_load;
	logic [7:0]       rdata_ff, nxt_rdata;

	// ****************************************
	// Decode
	// ****************************************
	logic             free_run, in_int, cap, mode_chg, end_period, latch, enter;
	logic             tmr_done, meas_sns, meas_bus, meas_pwr;
	logic [2:0]       col;
	logic [3:0]       i_shift, v_shift, p_shift, sample_count_select_log2n, cnt_log2n;
	logic [15:0]      s_res, b_res, p_res;
	logic             s_ovf, b_ovf, p_ovf;

	always_comb begin
		free_run   = mode_act_ff != MODE_PIN_POWER;
		in_int     = st_ff == ST_INTEG;
		cap        = cnt_ff == CNT_W'(MAX_SAMPLES);
		mode_chg   = mode_ff != mode_act_ff;
		end_period = in_int && integrate_req && (cap                  // R19
			|| (free_run && tmr_done)                                   // R1 R16
			|| (!free_run && mode_chg));                                // R15
		latch      = end_period || (in_int && !integrate_req && !free_run); // R18
		enter      = (st_ff == ST_READ) && integrate_req;
		i_shift    = {1'b0, gain_cfg_ff[GAIN_I_LSB +: 3]}; // R2 R3
		v_shift    = {1'b0, (gain_cfg_ff[GAIN_V_LSB +: 3] > BUS_GAIN_MAX) ? BUS_GAIN_MAX
			: gain_cfg_ff[GAIN_V_LSB +: 3]}; // R4 R5
		p_shift    = i_shift + v_shift;
		sample_count_select_log2n = (int_act_ff[INT_SAMPLE_COUNT_SELECT_LSB +: 4] > 4'(MAX_LOG2N)) ? 4'(MAX_LOG2N)
			: int_act_ff[INT_SAMPLE_COUNT_SELECT_LSB +: 4];
		cnt_log2n  = '0;
		for (int b = 0; b < CNT_W; b++) begin
			if (cnt_ff[b]) begin
				cnt_log2n = 4'(b);
			end
		end
		// Mixed settings in power fall into the mixed column
		if (mode_act_ff == MODE_FREE_SENSE) begin
			col = int_act_ff[INT_IRES_BIT] ? COL_S11 : COL_S14F;
		end else if (mode_act_ff == MODE_FREE_BUS) begin
			col = int_act_ff[INT_VRES_BIT] ? COL_S11 : COL_S14F;
		end else if (int_act_ff[1:0] == 2'h0 && int_act_ff[7:6] == 2'h3) begin
			col = COL_P14F;
		end else if (int_act_ff[1:0] == 2'h3 && int_act_ff[7:6] == 2'h0) begin
			col = COL_P11;
		end else begin
			col = COL_PMIX;
		end
		meas_sns = held_mode_ff != MODE_FREE_BUS;    // R17
		meas_bus = held_mode_ff != MODE_FREE_SENSE;
		meas_pwr = held_mode_ff == MODE_PIN_POWER || held_mode_ff == MODE_FREE_POWER;
	end

	// ****************************************
	// Period timer and result scalers
	// ****************************************
	igoc_period_timer #(.TICK_CYC(TICK_CYC)) u_timer (
		.clk   (clk),
		.rstn  (rstn),
		.start (latch || enter),
		.run   (in_int && free_run),
		.col   (col),
		.log2n (sample_count_select_log2n),
		.done  (tmr_done)
	);

	igoc_result_scaler #(.DW(SMP_W), .AW(IAW)) u_sns (
		.acc    (held_i_ff),
		.log2n  (held_log2n_ff),
		.gshift (i_shift),
		.result (s_res),
		.ovf    (s_ovf)
	);

	igoc_result_scaler #(.DW(SMP_W), .AW(IAW)) u_bus (
		.acc    (held_v_ff),
		.log2n  (held_log2n_ff),
		.gshift (v_shift),
		.result (b_res),
		.ovf    (b_ovf)
	);

	igoc_result_scaler #(.DW(2 * SMP_W), .AW(PAW)) u_pwr (
		.acc    (held_p_ff),
		.log2n  (held_log2n_ff),
		.gshift (p_shift),
		.result (p_res),
		.ovf    (p_ovf)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_int_act = int_act_ff;
		nxt_mode_act = mode_act_ff;
		nxt_cnt = cnt_ff;
		nxt_acc_i = acc_i_ff;
		nxt_acc_v = acc_v_ff;
		nxt_acc_p = acc_p_ff;
		nxt_held_i = held_i_ff;
		nxt_held_v = held_v_ff;
		nxt_held_p = held_p_ff;
		nxt_held_log2n = held_log2n_ff;
		nxt_held_mode = held_mode_ff;
		nxt_calc = 1'b0;
		case (st_ff)
			ST_READ: begin
				nxt_mode_act = mode_ff;
				nxt_calc = recomp_ff; // R12
				if (integrate_req) begin
					nxt_st = ST_INTEG;
					nxt_int_act = int_cfg_ff; // R13
					nxt_cnt = '0;
					nxt_acc_i = '0;
					nxt_acc_v = '0;
					nxt_acc_p = '0;
				end
			end
			ST_INTEG: begin
				if (smp_valid && !cap) begin // R19
					nxt_cnt = cnt_ff + CNT_W'(1);
					if (mode_act_ff != MODE_FREE_BUS) begin
						nxt_acc_i = acc_i_ff + IAW'(sense_smp);
					end
					if (mode_act_ff != MODE_FREE_SENSE) begin
						nxt_acc_v = acc_v_ff + IAW'(bus_smp);
					end
					if (mode_act_ff == MODE_PIN_POWER || mode_act_ff == MODE_FREE_POWER) begin
						// Widen before multiplying so the product keeps all 28 bits
						nxt_acc_p = acc_p_ff + PAW'(sense_smp) * PAW'(bus_smp);
					end
				end
				// A sample that lands on the closing cycle is dropped, not carried over
				if (latch) begin
					nxt_held_i = acc_i_ff; // R9
					nxt_held_v = acc_v_ff;
					nxt_held_p = acc_p_ff;
					nxt_held_log2n = free_run ? sample_count_select_log2n : cnt_log2n;
					nxt_held_mode = mode_act_ff;
					nxt_calc = 1'b1;
				end
				if (latch || !integrate_req) begin
					nxt_cnt = '0; // R18
					nxt_acc_i = '0;
					nxt_acc_v = '0;
					nxt_acc_p = '0;
				end
				if (end_period && mode_chg) begin
					nxt_mode_act = mode_ff; // R15 R16
				end
				if (!integrate_req) begin
					nxt_st = ST_READ;
				end
			end
			default: nxt_st = ST_READ;
		endcase
	end

	// Results, flags and output DAC
	always_comb begin
		nxt_bus_res = bus_res_ff;
		nxt_sns_res = sns_res_ff;
		nxt_pwr_res = pwr_res_ff;
		nxt_ovf = ovf_ff;
		nxt_dac = dac_ff;
		nxt_dac_load = 1'b0;
		if (calc_ff) begin
			nxt_ovf[OVF_SNS_BIT] = meas_sns && s_ovf; // R6
			nxt_ovf[OVF_BUS_BIT] = meas_bus && b_ovf; // R10
			nxt_ovf[OVF_PWR_BIT] = meas_pwr && (p_ovf || s_ovf || b_ovf); // R6 R10
			if (meas_sns) begin
				nxt_sns_res = s_res; // R7
			end
			if (meas_bus) begin
				nxt_bus_res = b_res; // R11
			end
			if (meas_pwr) begin
				nxt_pwr_res = (p_ovf || s_ovf || b_ovf) ? RESULT_SAT : p_res; // R8
			end
			nxt_dac_load = 1'b1;
			case (held_mode_ff)
				MODE_FREE_SENSE: nxt_dac = meas_sns && s_ovf ? RESULT_SAT[15:6] : s_res[15:6];
				MODE_FREE_BUS:   nxt_dac = b_res[15:6];
				default:         nxt_dac = (p_ovf || s_ovf || b_ovf) ? RESULT_SAT[15:6]
					: p_res[15:6];
			endcase
		end
	end

	// ****************************************
	// Register port
	// ****************************************
	always_comb begin
		nxt_gain_cfg = gain_cfg_ff;
		nxt_int_cfg = int_cfg_ff;
		nxt_mode = mode_ff;
		// A new request written while one is consumed is kept
		nxt_recomp = recomp_ff && (st_ff != ST_READ);
		if (reg_wr) begin
			case (reg_addr)
				OFS_GAIN_CFG: nxt_gain_cfg = reg_wdata;
				OFS_INT_CFG:  nxt_int_cfg = reg_wdata;
				OFS_CTRL: begin
					nxt_mode = igoc_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
					nxt_recomp = nxt_recomp || reg_wdata[CTRL_RECOMP_BIT];
				end
				default: nxt_recomp = nxt_recomp;
			endcase
		end
		case (reg_addr)
			OFS_GAIN_CFG: nxt_rdata = gain_cfg_ff;
			OFS_INT_CFG:  nxt_rdata = int_cfg_ff;
			OFS_CTRL:     nxt_rdata = {5'h00, recomp_ff, mode_ff};
			OFS_BUS_HI:   nxt_rdata = bus_res_ff[15:8];
			OFS_BUS_LO:   nxt_rdata = bus_res_ff[7:0];
			OFS_SENSE_HI: nxt_rdata = sns_res_ff[15:8];
			OFS_SENSE_LO: nxt_rdata = sns_res_ff[7:0];
			OFS_OVF:      nxt_rdata = {5'h00, ovf_ff};
			OFS_PWR_HI:   nxt_rdata = pwr_res_ff[15:8];
			OFS_PWR_LO:   nxt_rdata = pwr_res_ff[7:0];
			default:      nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_ff <= ST_READ;
			gain_cfg_ff <= GAIN_CFG_RST;
			int_cfg_ff <= INT_CFG_RST;
			int_act_ff <= INT_CFG_RST;
			mode_ff <= igoc_mode_t'(MODE_RST);
			mode_act_ff <= igoc_mode_t'(MODE_RST);
			held_mode_ff <= igoc_mode_t'(MODE_RST);
			recomp_ff <= 1'b0;
			cnt_ff <= '0;
			acc_i_ff <= '0;
			acc_v_ff <= '0;
			acc_p_ff <= '0;
			held_i_ff <= '0;
			held_v_ff <= '0;
			held_p_ff <= '0;
			held_log2n_ff <= '0;
			calc_ff <= 1'b0;
			bus_res_ff <= '0;
			sns_res_ff <= '0;
			pwr_res_ff <= '0;
			ovf_ff <= '0;
			dac_ff <= '0;
			dac_load_ff <= 1'b0;
			rdata_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			gain_cfg_ff <= nxt_gain_cfg;
			int_cfg_ff <= nxt_int_cfg;
			int_act_ff <= nxt_int_act;
			mode_ff <= nxt_mode;
			mode_act_ff <= nxt_mode_act;
			held_mode_ff <= nxt_held_mode;
			recomp_ff <= nxt_recomp;
			cnt_ff <= nxt_cnt;
			acc_i_ff <= nxt_acc_i;
			acc_v_ff <= nxt_acc_v;
			acc_p_ff <= nxt_acc_p;
			held_i_ff <= nxt_held_i;
			held_v_ff <= nxt_held_v;
			held_p_ff <= nxt_held_p;
			held_log2n_ff <= nxt_held_log2n;
			calc_ff <= nxt_calc;
			bus_res_ff <= nxt_bus_res;
			sns_res_ff <= nxt_sns_res;
			pwr_res_ff <= nxt_pwr_res;
			ovf_ff <= nxt_ovf;
			dac_ff <= nxt_dac;
			dac_load_ff <= nxt_dac_load;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign dac_value = dac_ff;
	assign dac_load = dac_load_ff;
	assign integrating = st_ff == ST_INTEG;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence calc_then_load;
		calc_ff ##1 dac_load_ff;
	endsequence

	a_recompute_read: assert property ((st_ff == ST_READ) && recomp_ff |=> calc_then_load) // R12
		else $error("recompute request did not refresh output");
	a_cap_ends: assert property (in_int && integrate_req && cap |=> calc_then_load) // R19
		else $error("sample cap did not end integration");
	a_free_discard: assert property (in_int && !integrate_req && free_run && !cap
		|=> !calc_ff ##1 !dac_load_ff) // R18
		else $error("partial free-run period was not discarded");
	a_pin_switch: assert property (in_int && integrate_req && !free_run && mode_chg
		|=> mode_act_ff == $past(mode_ff) ##0 calc_then_load) // R15
		else $error("pin-controlled mode change not handled at once");
	a_free_hold: assert property (in_int && free_run && mode_chg && !end_period
		|=> $stable(mode_act_ff)) // R16
		else $error("free-run mode switched before period end");
	a_cfg_defer: assert property (in_int && $past(in_int) |-> $stable(int_act_ff)) // R13
		else $error("integration settings changed during Integrate");
	a_bus_gain_cap: assert property (gain_cfg_ff[GAIN_V_LSB +: 3] >= BUS_GAIN_MAX
		|-> v_shift == 4'h5) // R4
		else $error("bus gain above 32X");
	a_sense_sat: assert property (calc_ff && meas_sns && s_ovf
		|=> sns_res_ff == 16'hFFC0 && ovf_ff[OVF_SNS_BIT]) // R7
		else $error("sense overflow did not saturate");
	a_bus_sat: assert property (calc_ff && meas_bus && b_ovf
		|=> bus_res_ff == 16'hFFC0 && ovf_ff[OVF_BUS_BIT]) // R11
		else $error("bus overflow did not saturate");
	a_power_sat: assert property (calc_ff && meas_pwr && p_ovf
		|=> pwr_res_ff == 16'hFFC0 && ovf_ff[OVF_PWR_BIT]) // R8
		else $error("power overflow did not saturate");
	a_accum_kept: assert property (calc_ff && !$past(calc_ff) && !latch |=> $stable(held_p_ff)) // R9
		else $error("held accumulator disturbed by calculation");

endmodule

// ==== verif/igoc_host.sv ====
/*
 * Host partner: drives the register port and the power state.
 * Assumes one clock; all changes land on the falling edge.
 */
`timescale 1ns/10ps
module igoc_host (
	// Clock
	input  wire logic       clk,
	// Register port
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	// Power state
	output logic            integrate_req
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		integrate_req = 1'b0;
	end

	// Write strobe lasts exactly one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask

	// Read data trails the address by one edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask

	task automatic state(input logic s);
		@(negedge clk);
		integrate_req = s;
	endtask
endmodule

// ==== verif/tb_top.sv ====
/*
 * Self-checking bench for the integration, gain and overflow block.
 * Assumes the tick divider can be set to one cycle per microsecond.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top import igoc_pkg::*;;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, integrate_req, dac_load, integrating;
	logic smp_valid = 1'b0;
	logic [SMP_W-1:0] sense_smp = '0;
	logic [SMP_W-1:0] bus_smp = '0;
	logic [9:0] dac_value;
	int n_mismatch = 0;
	int check_count = 0;
	logic [15:0] sat = 16'hFFC0;

	always #4 clk = ~clk;

	igoc_host host_u (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .integrate_req(integrate_req));
	// One cycle per tick keeps free-run periods short
	igoc_top #(.TICK_CYC(1)) dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.integrate_req(integrate_req), .smp_valid(smp_valid), .sense_smp(sense_smp),
		.bus_smp(bus_smp), .dac_value(dac_value), .dac_load(dac_load),
		.integrating(integrating));

	task automatic summarize;
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wait_load(output int n);
		for (n = 0; n < 700 && dac_load !== 1'b1; n++)
			@(negedge clk);
		if (n == 700) begin
			n_mismatch++;
			summarize();
		end
	endtask

	task automatic chk(input logic [7:0] ofs, input logic [15:0] e);
		logic [7:0] hi, lo;
		host_u.rd(ofs, hi);
		host_u.rd(ofs + 8'h01, lo);
		`CHK({hi, lo}, e)
	endtask

	// Pin mode: four paired samples, then Read latches the result
	task automatic meas(input logic [13:0] s, input logic [13:0] b);
		int n;
		host_u.state(1'b1);
		repeat (4) begin
			@(negedge clk);
			{smp_valid, sense_smp, bus_smp} = {1'b1, s, b};
			@(negedge clk);
			smp_valid = 1'b0;
		end
		host_u.state(1'b0);
		wait_load(n);
	endtask

	task automatic s_sense_gain;
		logic [7:0] f;
		host_u.wr(OFS_GAIN_CFG, 8'h07);
		meas(14'h1000, 14'h2000);
		`CHK(dac_value, 10'h3FF)
		host_u.rd(OFS_OVF, f);
		`CHK(f, 8'h05)
		chk(OFS_SENSE_HI, sat);
		chk(OFS_PWR_HI, sat);
		chk(OFS_BUS_HI, 16'h8000);
		// Gain steps re-applied to held sums without new samples
		for (int g = 0; g < 4; g++) begin
			int n;
			host_u.wr(OFS_GAIN_CFG, 8'(g));
			host_u.wr(OFS_CTRL, 8'h04);
			wait_load(n);
			host_u.rd(OFS_OVF, f);
			`CHK(f, (g < 2) ? 8'h00 : 8'h05)
			chk(OFS_SENSE_HI, (g < 2) ? 16'h4000 << g : sat);
			chk(OFS_PWR_HI, (g < 2) ? 16'h2000 << g : sat);
		end
	endtask

	task automatic s_bus_gain;
		logic [7:0] f;
		meas(14'h1000, 14'h0200);
		for (int v = 3; v < 8; v++) begin
			int n;
			host_u.wr(OFS_GAIN_CFG, 8'(v << 3));
			host_u.wr(OFS_CTRL, 8'h04);
			wait_load(n);
			host_u.rd(OFS_OVF, f);
			`CHK(f, (v < 5) ? 8'h00 : 8'h03)
			chk(OFS_BUS_HI, (v < 5) ? 16'h4000 << (v - 3) : sat);
			chk(OFS_PWR_HI, (v < 5) ? 16'h1000 << (v - 3) : sat);
		end
	endtask

	task automatic s_free_run;
		int n;
		host_u.wr(OFS_GAIN_CFG, 8'h00);
		// Settings changed only while in Read
		host_u.wr(OFS_INT_CFG, 8'hC1);
		host_u.wr(OFS_CTRL, 8'h01);
		host_u.state(1'b1);
		wait_load(n);
		`CHK(n >= 508 && n <= 516, 1'b1)
		repeat (100) @(negedge clk);
		host_u.state(1'b0);
		for (n = 0; n < 600 && dac_load !== 1'b1; n++)
			@(negedge clk);
		`CHK(n, 600)
	endtask

	initial begin
		logic [7:0] f;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		host_u.rd(OFS_OVF, f);
		`CHK(f, 8'h00)
		host_u.rd(8'h05, f);
		`CHK(f, 8'h00)
		s_sense_gain();
		s_bus_gain();
		s_free_run();
		summarize();
	end
endmodule
